// >>> logic/ctbic_pkg.sv
// Contract
// [R01] wake enable set: a wake-up event raises a wake interrupt request
// [R02] status-change enable set: pending status-change flag raises error request
// [R03] rx sensitivity 11 all, 10 error/bus-off edges, 01 bus-off, 00 none
// [R04] tx sensitivity 11 all, 10 error/bus-off edges, 01 bus-off, 00 none
// [R05] bus state flags track real state, frozen while status-change flag pending
// [R06] overrun enable set: overrun flag raises error request
// [R07] receive-full enable set: receive-full flag raises receive request
// [R08] receiver enable register readable always, writable only outside init mode
// [R09] sensitivity fields keep their value through init mode
// [R10] transmit registers forced to reset while init mode, writable after
// [R11] outside init, writing 1 clears an empty flag, 0 ignored
// [R12] cpu loads a buffer fully before clearing its empty flag
// [R13] empty flag set on successful send or granted abort
// [R14] per-buffer enable lets a set empty flag raise transmit request
// [R15] clearing an empty flag clears its abort acknowledge
// [R16] listen-only: empty flags cannot clear, no transmission starts
// [R17] accesses blocked to a scheduled buffer with empty flag clear
// [R18] abort granted if not started, or failed by lost arbitration or error
// [R19] granted abort sets empty and acknowledge, interrupt if enabled
// [R20] cpu never clears abort request; cleared when empty flag sets
// [R21] abort acknowledge bits read-only, mark aborted rather than sent
// [R22] buffer select reads lowest set bit only, writable outside init
// [R23] lowest set select bit chooses the foreground buffer
// [R24] no buffer selected: foreground window accesses refused
// [R25] transmit request is OR of empty flag AND enable per buffer
package ctbic_pkg;

  // ==========================================================================
  // sizes
  localparam int          NUM_TX_BUF = 3;
  localparam int          ADDR_W     = 12;

  // ==========================================================================
  // register offsets
  localparam logic [11:0] OFF_RIER   = 12'h000;
  localparam logic [11:0] OFF_TFLG   = 12'h004;
  localparam logic [11:0] OFF_TIER   = 12'h008;
  localparam logic [11:0] OFF_TARQ   = 12'h00C;
  localparam logic [11:0] OFF_TAAK   = 12'h010;
  localparam logic [11:0] OFF_TBSEL  = 12'h014;
  localparam logic [11:0] OFF_STAT   = 12'h018;

  // ==========================================================================
  // receiver enable fields
  localparam int          B_WAKE_IE  = 7;
  localparam int          B_CSC_IE   = 6;
  localparam int          B_RSENS_H  = 5;
  localparam int          B_RSENS_L  = 4;
  localparam int          B_TSENS_H  = 3;
  localparam int          B_TSENS_L  = 2;
  localparam int          B_OVR_IE   = 1;
  localparam int          B_RXF_IE   = 0;

  // status fields: wake flag, status-change flag, rx state, tx state, ovr, rxf
  localparam int          B_WAKE_F   = 7;
  localparam int          B_CSC_F    = 6;
  localparam int          B_RST_L    = 4;
  localparam int          B_TST_L    = 2;

  // ==========================================================================
  // reset values, bus state and sensitivity codes
  localparam logic [7:0]  RST_RIER   = 8'h00;
  localparam logic [2:0]  RST_TFLG   = 3'h7;
  localparam logic [2:0]  RST_ZERO3  = 3'h0;
  localparam logic [1:0]  ST_OK      = 2'h0;
  localparam logic [1:0]  ST_BUSOFF  = 2'h3;
  localparam logic [1:0]  SENS_ALL   = 2'h3;
  localparam logic [1:0]  SENS_ERR   = 2'h2;
  localparam logic [1:0]  SENS_BOFF  = 2'h1;

  // ==========================================================================
  // carriers
  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [11:0]       paddr;
    logic [31:0]       pwdata;
  } ctbic_apb_t;

  typedef struct packed {
    logic              wake_event;
    logic              overrun_flag;
    logic              rx_full_flag;
    logic [1:0]        rx_state;
    logic [1:0]        tx_state;
    logic [2:0]        tx_done;
    logic [2:0]        tx_started;
    logic [2:0]        tx_failed;
  } ctbic_eng_t;

endpackage

// >>> logic/ctbic_core.sv
`timescale 1ns/1ps
`default_nettype none
module ctbic_core (
  input  wire logic                  i_clk,
  input  wire logic                  i_nrst,
  input  wire ctbic_pkg::ctbic_apb_t i_apb,
  input  wire ctbic_pkg::ctbic_eng_t i_eng,
  input  wire logic                  i_init_request,
  input  wire logic                  i_init_acknowledge,
  input  wire logic                  i_listen_only,
  output logic                       o_pready,
  output logic [31:0]                o_prdata,
  output logic                       o_pslverr,
  output logic                       o_wake_irq,
  output logic                       o_err_irq,
  output logic                       o_rx_irq,
  output logic                       o_tx_irq,
  output logic [2:0]                 o_tx_sched,
  output logic [2:0]                 o_fg_sel,
  output logic                       o_fg_access_ok,
  output logic [1:0]                 o_rx_bus_state,
  output logic [1:0]                 o_tx_bus_state
);

  // ==========================================================================
  // state
  logic [7:0]  rier_q,  rier_d;
  logic [2:0]  tflg_q,  tflg_d;
  logic [2:0]  tier_q,  tier_d;
  logic [2:0]  arq_q,   arq_d;
  logic [2:0]  aak_q,   aak_d;
  logic [2:0]  tbsel_q, tbsel_d;
  logic        wake_q,  wake_d;
  logic        csc_q,   csc_d;
  logic [1:0]  rx_q,    rx_d;
  logic [1:0]  tx_q,    tx_d;
  logic        pready_q, pready_d;
  logic [31:0] prdata_q, prdata_d;
  logic        pslverr_q, pslverr_d;
  logic        wake_irq_q, wake_irq_d;
  logic        err_irq_q, err_irq_d;
  logic        rx_irq_q, rx_irq_d;
  logic        tx_irq_q, tx_irq_d;
  logic [2:0]  sched_q, sched_d;
  logic [2:0]  fgsel_q, fgsel_d;
  logic        fgok_q, fgok_d;

  logic        init_mode;
  logic        acc_done;
  logic        wr;
  logic [7:0]  wdat;
  logic [2:0]  grant;
  logic [2:0]  set_empty;
  logic [2:0]  tbsel_low;

  // ==========================================================================
  // helpers
  function automatic logic sens_hit(input logic [1:0] sens, input logic [1:0] old_st,
                                    input logic [1:0] new_st);
    logic hit;
    hit = 1'b0;
    case (sens)
      ctbic_pkg::SENS_ALL:  hit = 1'b1;
      ctbic_pkg::SENS_ERR:  hit = old_st[1] | new_st[1];
      ctbic_pkg::SENS_BOFF: hit = (old_st == ctbic_pkg::ST_BUSOFF) | (new_st == ctbic_pkg::ST_BUSOFF);
      default:              hit = 1'b0;
    endcase
    return hit;
  endfunction

  assign init_mode = i_init_request & i_init_acknowledge;
  assign acc_done  = i_apb.psel & i_apb.penable & pready_q;
  assign wr        = acc_done & i_apb.pwrite;
  assign wdat      = i_apb.pwdata[7:0];
  assign tbsel_low = tbsel_q & (~tbsel_q + 3'h1); // R22 R23

  // ==========================================================================
  // abort grant and empty-flag set sources
  genvar gi;
  generate
    for (gi = 0; gi < ctbic_pkg::NUM_TX_BUF; gi++) begin : g_buf
      assign grant[gi]     = arq_q[gi] & ~tflg_q[gi]
                             & (~i_eng.tx_started[gi] | i_eng.tx_failed[gi]); // R18
      assign set_empty[gi] = grant[gi] | (i_eng.tx_done[gi] & ~tflg_q[gi]);    // R13
    end
  endgenerate

  // ==========================================================================
  // register next state
  always_comb begin
    logic rx_chg;
    logic tx_chg;
    rx_chg  = 1'b0;
    tx_chg  = 1'b0;
    rier_d  = rier_q;
    tflg_d  = tflg_q;
    tier_d  = tier_q;
    arq_d   = arq_q;
    aak_d   = aak_q;
    tbsel_d = tbsel_q;
    wake_d  = wake_q;
    csc_d   = csc_q;
    rx_d    = rx_q;
    tx_d    = tx_q;

    if (wr && !init_mode) begin
      case (i_apb.paddr)
        ctbic_pkg::OFF_RIER:  rier_d = wdat; // R08
        ctbic_pkg::OFF_TFLG: begin
          if (!i_listen_only) begin
            tflg_d = tflg_q & ~wdat[2:0]; // R11 R16
            aak_d  = aak_q & ~(tflg_q & wdat[2:0]); // R15
          end
        end
        ctbic_pkg::OFF_TIER:  tier_d  = wdat[2:0];
        ctbic_pkg::OFF_TARQ:  arq_d   = arq_q | wdat[2:0]; // R20
        ctbic_pkg::OFF_TBSEL: tbsel_d = wdat[2:0]; // R22
        ctbic_pkg::OFF_STAT: begin
          wake_d = wake_q & ~wdat[ctbic_pkg::B_WAKE_F];
          csc_d  = csc_q & ~wdat[ctbic_pkg::B_CSC_F];
        end
        default: begin
        end
      endcase
    end

    // hardware sets win over software clears
    tflg_d = tflg_d | set_empty; // R13
    aak_d  = aak_d | grant; // R19
    arq_d  = arq_d & ~tflg_d; // R20
    if (i_eng.wake_event) begin
      wake_d = 1'b1;
    end

    // bus state tracking, frozen while the status-change flag is pending
    if (!csc_q) begin // R05
      rx_d   = i_eng.rx_state;
      tx_d   = i_eng.tx_state;
      rx_chg = (i_eng.rx_state != rx_q)
               && sens_hit(rier_q[ctbic_pkg::B_RSENS_H:ctbic_pkg::B_RSENS_L], rx_q, i_eng.rx_state); // R03
      tx_chg = (i_eng.tx_state != tx_q)
               && sens_hit(rier_q[ctbic_pkg::B_TSENS_H:ctbic_pkg::B_TSENS_L], tx_q, i_eng.tx_state); // R04
      if (rx_chg || tx_chg) begin
        csc_d = 1'b1;
      end
    end

    if (init_mode) begin // R10
      rier_d = {ctbic_pkg::RST_RIER[7:6], rier_q[ctbic_pkg::B_RSENS_H:ctbic_pkg::B_TSENS_L],
                ctbic_pkg::RST_RIER[1:0]}; // R09
      tflg_d  = ctbic_pkg::RST_TFLG;
      tier_d  = ctbic_pkg::RST_ZERO3;
      arq_d   = ctbic_pkg::RST_ZERO3;
      aak_d   = ctbic_pkg::RST_ZERO3;
      tbsel_d = ctbic_pkg::RST_ZERO3;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rier_q  <= ctbic_pkg::RST_RIER;
      tflg_q  <= ctbic_pkg::RST_TFLG;
      tier_q  <= ctbic_pkg::RST_ZERO3;
      arq_q   <= ctbic_pkg::RST_ZERO3;
      aak_q   <= ctbic_pkg::RST_ZERO3;
      tbsel_q <= ctbic_pkg::RST_ZERO3;
      wake_q  <= 1'b0;
      csc_q   <= 1'b0;
      rx_q    <= ctbic_pkg::ST_OK;
      tx_q    <= ctbic_pkg::ST_OK;
    end else begin
      rier_q  <= rier_d;
      tflg_q  <= tflg_d;
      tier_q  <= tier_d;
      arq_q   <= arq_d;
      aak_q   <= aak_d;
      tbsel_q <= tbsel_d;
      wake_q  <= wake_d;
      csc_q   <= csc_d;
      rx_q    <= rx_d;
      tx_q    <= tx_d;
    end
  end

  // ==========================================================================
  // apb slave: ready one cycle into the access phase, data captured with it
  always_comb begin
    pready_d  = 1'b0;
    prdata_d  = prdata_q;
    pslverr_d = 1'b0;
    if (i_apb.psel && i_apb.penable && !pready_q) begin
      pready_d = 1'b1;
      prdata_d = 32'h0000_0000;
      case (i_apb.paddr)
        ctbic_pkg::OFF_RIER:  prdata_d[7:0] = rier_q;
        ctbic_pkg::OFF_TFLG:  prdata_d[2:0] = tflg_q;
        ctbic_pkg::OFF_TIER:  prdata_d[2:0] = tier_q;
        ctbic_pkg::OFF_TARQ:  prdata_d[2:0] = arq_q;
        ctbic_pkg::OFF_TAAK:  prdata_d[2:0] = aak_q; // R21
        ctbic_pkg::OFF_TBSEL: prdata_d[2:0] = tbsel_low; // R22
        ctbic_pkg::OFF_STAT: begin
          prdata_d[ctbic_pkg::B_WAKE_F]                     = wake_q;
          prdata_d[ctbic_pkg::B_CSC_F]                      = csc_q;
          prdata_d[ctbic_pkg::B_RST_L+1:ctbic_pkg::B_RST_L] = rx_q;
          prdata_d[ctbic_pkg::B_TST_L+1:ctbic_pkg::B_TST_L] = tx_q;
          prdata_d[ctbic_pkg::B_OVR_IE]                     = i_eng.overrun_flag;
          prdata_d[ctbic_pkg::B_RXF_IE]                     = i_eng.rx_full_flag;
        end
        default:              pslverr_d = 1'b1;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= pready_d;
      prdata_q  <= prdata_d;
      pslverr_q <= pslverr_d;
    end
  end

  // ==========================================================================
  // requests and engine-facing outputs
  always_comb begin
    wake_irq_d = wake_q & rier_q[ctbic_pkg::B_WAKE_IE]; // R01
    err_irq_d  = (csc_q & rier_q[ctbic_pkg::B_CSC_IE]) // R02
                 | (i_eng.overrun_flag & rier_q[ctbic_pkg::B_OVR_IE]); // R06
    rx_irq_d   = i_eng.rx_full_flag & rier_q[ctbic_pkg::B_RXF_IE]; // R07
    tx_irq_d   = |(tflg_q & tier_q); // R14 R25
    sched_d    = ~tflg_q & {3{~i_listen_only}}; // R16
    fgsel_d    = tbsel_low; // R23
    fgok_d     = (tbsel_low != 3'h0) && ((tbsel_low & tflg_q) != 3'h0); // R17 R24
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      wake_irq_q <= 1'b0;
      err_irq_q  <= 1'b0;
      rx_irq_q   <= 1'b0;
      tx_irq_q   <= 1'b0;
      sched_q    <= ctbic_pkg::RST_ZERO3;
      fgsel_q    <= ctbic_pkg::RST_ZERO3;
      fgok_q     <= 1'b0;
    end else begin
      wake_irq_q <= wake_irq_d;
      err_irq_q  <= err_irq_d;
      rx_irq_q   <= rx_irq_d;
      tx_irq_q   <= tx_irq_d;
      sched_q    <= sched_d;
      fgsel_q    <= fgsel_d;
      fgok_q     <= fgok_d;
    end
  end

  assign o_pready       = pready_q;
  assign o_prdata       = prdata_q;
  assign o_pslverr      = pslverr_q;
  assign o_wake_irq     = wake_irq_q;
  assign o_err_irq      = err_irq_q;
  assign o_rx_irq       = rx_irq_q;
  assign o_tx_irq       = tx_irq_q;
  assign o_tx_sched     = sched_q;
  assign o_fg_sel       = fgsel_q;
  assign o_fg_access_ok = fgok_q;
  assign o_rx_bus_state = rx_q;
  assign o_tx_bus_state = tx_q;

  // ==========================================================================
  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  wake_irq_a: assert property (wake_q && rier_q[ctbic_pkg::B_WAKE_IE] |=> o_wake_irq) // R01
    else $error("wake request missing");

  err_irq_a: assert property (csc_q && rier_q[ctbic_pkg::B_CSC_IE] |=> o_err_irq) // R02
    else $error("status change error request missing");

  ovr_irq_a: assert property (!i_eng.overrun_flag && !csc_q |=> !o_err_irq) // R06
    else $error("error request without cause");

  rx_irq_a: assert property (o_rx_irq |-> $past(i_eng.rx_full_flag) && $past(rier_q[ctbic_pkg::B_RXF_IE])) // R07
    else $error("receive request without cause");

  state_hold_a: assert property ($past(csc_q) |-> rx_q == $past(rx_q) && tx_q == $past(tx_q)) // R05
    else $error("bus state moved while change pending");

  sens_keep_a: assert property (init_mode |=> rier_q[5:2] == $past(rier_q[5:2]) && rier_q[7:6] == 2'h0) // R09
    else $error("sensitivity lost in init mode");

  init_force_a: assert property (init_mode |=> tflg_q == ctbic_pkg::RST_TFLG && tier_q == 3'h0
                                 && arq_q == 3'h0 && aak_q == 3'h0 && tbsel_q == 3'h0) // R10
    else $error("transmit registers not held in init mode");

  txe_clear_a: assert property (wr && i_apb.paddr == ctbic_pkg::OFF_TFLG && !init_mode && !i_listen_only
                                |=> (tflg_q & $past(wdat[2:0]) & ~$past(set_empty)) == 3'h0) // R11
    else $error("empty flag write-one-clear failed");

  listen_a: assert property (i_listen_only |=> o_tx_sched == 3'h0 && tflg_q == ($past(tflg_q) | $past(set_empty))
                             || $past(init_mode)) // R16
    else $error("transmission scheduled in listen-only");

  abort_ack_a: assert property (|grant && !init_mode |=> (tflg_q & aak_q & $past(grant)) == $past(grant)) // R19
    else $error("granted abort not flagged");

  ack_clear_a: assert property (((~tflg_q & $past(tflg_q)) & aak_q) == 3'h0) // R15
    else $error("acknowledge survived empty clear");

  arq_clear_a: assert property ((tflg_q & arq_q) == 3'h0) // R20
    else $error("abort request left on empty buffer");

  fg_sel_a: assert property ($onehot0(o_fg_sel) && ((o_fg_sel == 3'h0) == ($past(tbsel_q) == 3'h0))
                             && ((o_fg_sel - 3'h1) & $past(tbsel_q) & ~o_fg_sel) == 3'h0) // R22 R23
    else $error("foreground select not lowest bit");

  tx_irq_a: assert property (o_tx_irq == |($past(tflg_q) & $past(tier_q))) // R25
    else $error("transmit request mismatch");

  // ==========================================================================
  // checks on masks, writes and hardware-owned bits
  wake_mask_a: assert property (!rier_q[ctbic_pkg::B_WAKE_IE] |=> !o_wake_irq) // R01
    else $error("wake request while masked");

  err_mask_a: assert property (!rier_q[ctbic_pkg::B_CSC_IE] && !rier_q[ctbic_pkg::B_OVR_IE] // R02 R06
                               |=> !o_err_irq)
    else $error("error request while masked");

  ovr_set_a: assert property (i_eng.overrun_flag && rier_q[ctbic_pkg::B_OVR_IE] |=> o_err_irq) // R06
    else $error("overrun request missing");

  rx_set_a: assert property (i_eng.rx_full_flag && rier_q[ctbic_pkg::B_RXF_IE] |=> o_rx_irq) // R07
    else $error("receive request missing");

  state_track_a: assert property (!$past(csc_q) |-> rx_q == $past(i_eng.rx_state) // R05
                                  && tx_q == $past(i_eng.tx_state))
    else $error("bus state not tracking engine");

  rier_write_a: assert property (wr && i_apb.paddr == ctbic_pkg::OFF_RIER && !init_mode // R08
                                 |=> rier_q == $past(wdat))
    else $error("receiver enable write lost");

  tier_write_a: assert property (wr && i_apb.paddr == ctbic_pkg::OFF_TIER && !init_mode // R10
                                 |=> tier_q == $past(wdat[2:0]))
    else $error("transmit enable write lost");

  tbsel_write_a: assert property (wr && i_apb.paddr == ctbic_pkg::OFF_TBSEL && !init_mode // R22
                                  |=> tbsel_q == $past(wdat[2:0]))
    else $error("buffer select write lost");

  done_set_a: assert property (!init_mode |=> (~tflg_q & $past(i_eng.tx_done) & ~$past(tflg_q)) == 3'h0) // R13
    else $error("sent buffer not flagged empty");

  arq_keep_a: assert property (($past(arq_q) & ~arq_q & ~tflg_q) == 3'h0) // R20
    else $error("abort request dropped without empty flag");

  aak_rise_a: assert property ((aak_q & ~$past(aak_q) & ~$past(grant)) == 3'h0) // R21
    else $error("acknowledge set without granted abort");

  fg_block_a: assert property (o_fg_access_ok |-> (o_fg_sel & $past(tflg_q)) != 3'h0) // R17
    else $error("window open on scheduled buffer");

  fg_none_a: assert property (o_fg_sel == 3'h0 |-> !o_fg_access_ok) // R24
    else $error("window open with no buffer selected");

  sched_listen_a: assert property (o_tx_sched != 3'h0 |-> !$past(i_listen_only)) // R16
    else $error("buffer scheduled in listen-only");

endmodule
`default_nettype wire

// >>> bench/ctbic_engine_model.sv
`timescale 1ns/1ps
`default_nettype none
module ctbic_engine_model (
  input  wire logic                  i_clk,
  input  wire logic                  i_nrst,
  input  wire logic [2:0]            i_tx_sched,
  input  wire logic                  i_stall,
  input  wire logic [2:0]            i_fail,
  input  wire ctbic_pkg::ctbic_eng_t i_status,
  output var  ctbic_pkg::ctbic_eng_t o_eng
);
  // ==========================================================================
  // per-buffer frame timing
  logic [2:0] busy_q;
  logic [2:0] done_q;
  int         cnt_q [3];

  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      busy_q <= '0;
      done_q <= '0;
    end else begin
      for (int b = 0; b < 3; b++) begin
        done_q[b] <= 1'b0;
        if (busy_q[b]) begin
          cnt_q[b] <= cnt_q[b] + 1;
          done_q[b] <= (cnt_q[b] == 5);
          if (!i_tx_sched[b]) busy_q[b] <= 1'b0;
        end else if (i_tx_sched[b] && !i_stall) begin
          busy_q[b] <= 1'b1;
          cnt_q[b] <= 0;
        end
      end
    end
  end

  // ==========================================================================
  // engine outputs
  always_comb begin
    o_eng            = i_status;
    o_eng.tx_done    = done_q;
    o_eng.tx_started = busy_q;
    o_eng.tx_failed  = i_fail;
  end
endmodule
`default_nettype wire

// >>> bench/can_tx_buffer_irq_control_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module can_tx_buffer_irq_control_tb_top;
  // ==========================================================================
  // signals
  logic                  i_clk;
  logic                  i_nrst;
  ctbic_pkg::ctbic_apb_t apb;
  ctbic_pkg::ctbic_eng_t bus;
  ctbic_pkg::ctbic_eng_t eng;
  logic                  init_rq, init_ak, listen, stall, pready, perr, err_s;
  logic                  wake_irq, err_irq, rx_irq, tx_irq, fg_ok;
  logic [31:0]           prdata, rd;
  logic [2:0]            sched, fg_sel, fail;
  logic [1:0]            rxs, txs;
  logic [7:0]            v;
  int                    failures, checks, e;
  int                    rst_exp [6] = '{0, 7, 0, 0, 0, 0};

  ctbic_core ctbic_core_inst (.i_clk(i_clk), .i_nrst(i_nrst), .i_apb(apb), .i_eng(eng),
    .i_init_request(init_rq), .i_init_acknowledge(init_ak), .i_listen_only(listen),
    .o_pready(pready), .o_prdata(prdata), .o_pslverr(perr), .o_wake_irq(wake_irq),
    .o_err_irq(err_irq), .o_rx_irq(rx_irq), .o_tx_irq(tx_irq), .o_tx_sched(sched),
    .o_fg_sel(fg_sel), .o_fg_access_ok(fg_ok), .o_rx_bus_state(rxs), .o_tx_bus_state(txs));

  ctbic_engine_model ctbic_engine_model_inst (.i_clk(i_clk), .i_nrst(i_nrst), .i_tx_sched(sched),
    .i_stall(stall), .i_fail(fail), .i_status(bus), .o_eng(eng));

  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end

  // ==========================================================================
  // reference model and helpers
  function automatic int aff(int s, int a, int b);
    if (a == b || s == 0) return 0;
    if (s == 3) return 1;
    if (s == 2) return int'(a >= 2 || b >= 2);
    return int'(a == 3 || b == 3);
  endfunction

  task automatic final_report();
    if (failures == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask

  task automatic xfer(input logic wr, input logic [11:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge i_clk);
    apb <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: {24'h0, d}};
    @(posedge i_clk);
    apb.penable <= 1'b1;
    do begin
      @(posedge i_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err_s = perr;
    cmp(n < 20, 1);
    apb <= '0;
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [7:0] x);
    xfer(1'b0, a, 8'h0);
    cmp(rd, {24'h0, x});
  endtask

  initial begin
    repeat (20000) @(posedge i_clk);
    failures++;
    final_report();
  end

  // ==========================================================================
  // main sequence
  initial begin
    i_nrst = 1'b0;
    apb = '0;
    bus = '0;
    {init_rq, init_ak, listen} = 3'h0;
    stall = 1'b1;
    fail = 3'h0;
    failures = 0;
    checks = 0;
    void'($urandom(32'hfcf0_9538));
    repeat (20) @(posedge i_clk);
    i_nrst <= 1'b1;
    foreach (rst_exp[i]) rdchk(12'(4 * i), 8'(rst_exp[i]));
    xfer(1'b0, 12'h01C, 8'h0);
    cmp(err_s, 1);
    // enables against wake pulse, overrun and receive-full levels
    bus.overrun_flag <= 1'b1;
    bus.rx_full_flag <= 1'b1;
    repeat (6) begin
      v = 8'($urandom()) & 8'hC3;
      xfer(1'b1, ctbic_pkg::OFF_RIER, v);
      rdchk(ctbic_pkg::OFF_RIER, v);
      bus.wake_event <= 1'b1;
      @(posedge i_clk);
      bus.wake_event <= 1'b0;
      tick(3);
      cmp({wake_irq, err_irq, rx_irq}, {v[7], v[1], v[0]});
      xfer(1'b1, ctbic_pkg::OFF_STAT, 8'h80);
    end
    bus <= '0;
    // status-change sensitivity for both sides
    for (int sd = 0; sd < 2; sd++) begin
      for (int s = 0; s < 4; s++) begin
        for (int n = 1; n < 4; n++) begin
          xfer(1'b1, ctbic_pkg::OFF_RIER, 8'h40 | 8'(s << (sd ? 2 : 4)));
          if (sd) bus.tx_state <= 2'(n);
          else bus.rx_state <= 2'(n);
          tick(4);
          e = aff(s, 0, n);
          cmp(err_irq, e);
          rdchk(ctbic_pkg::OFF_STAT, 8'((e << 6) | (n << (sd ? 2 : 4))));
          bus.tx_state <= 2'h0;
          bus.rx_state <= 2'h0;
          tick(4);
          cmp(sd ? txs : rxs, e ? n : 0);
          xfer(1'b1, ctbic_pkg::OFF_RIER, 8'h0);
          tick(2);
          cmp(err_irq, 0);
          xfer(1'b1, ctbic_pkg::OFF_STAT, 8'h40);
          tick(4);
          cmp({rxs, txs}, 0);
        end
      end
    end
    // transmit buffers, listen-only, selection, abort
    xfer(1'b1, ctbic_pkg::OFF_TIER, 8'h07);
    tick(3);
    cmp(tx_irq, 1);
    listen <= 1'b1;
    xfer(1'b1, ctbic_pkg::OFF_TFLG, 8'h01);
    rdchk(ctbic_pkg::OFF_TFLG, 8'h07);
    cmp(sched, 0);
    listen <= 1'b0;
    xfer(1'b1, ctbic_pkg::OFF_TBSEL, 8'h06);
    rdchk(ctbic_pkg::OFF_TBSEL, 8'h02);
    cmp({fg_sel, fg_ok}, {3'h2, 1'b1});
    xfer(1'b1, ctbic_pkg::OFF_TFLG, 8'h03);
    rdchk(ctbic_pkg::OFF_TFLG, 8'h04);
    cmp({sched, fg_ok}, {3'h3, 1'b0});
    listen <= 1'b1;
    tick(3);
    cmp(sched, 0);
    listen <= 1'b0;
    xfer(1'b1, ctbic_pkg::OFF_TIER, 8'h03);
    tick(3);
    cmp(tx_irq, 0);
    xfer(1'b1, ctbic_pkg::OFF_TAAK, 8'h07);
    rdchk(ctbic_pkg::OFF_TAAK, 8'h00);
    xfer(1'b1, ctbic_pkg::OFF_TARQ, 8'h01);
    tick(3);
    cmp(tx_irq, 1);
    rdchk(ctbic_pkg::OFF_TFLG, 8'h05);
    rdchk(ctbic_pkg::OFF_TAAK, 8'h01);
    rdchk(ctbic_pkg::OFF_TARQ, 8'h00);
    xfer(1'b1, ctbic_pkg::OFF_TFLG, 8'h01);
    rdchk(ctbic_pkg::OFF_TAAK, 8'h00);
    stall <= 1'b0;
    xfer(1'b1, ctbic_pkg::OFF_TARQ, 8'h02);
    tick(20);
    rdchk(ctbic_pkg::OFF_TFLG, 8'h07);
    rdchk(ctbic_pkg::OFF_TAAK, 8'h00);
    rdchk(ctbic_pkg::OFF_TARQ, 8'h00);
    xfer(1'b1, ctbic_pkg::OFF_TFLG, 8'h04);
    fail <= 3'h4;
    xfer(1'b1, ctbic_pkg::OFF_TARQ, 8'h04);
    rdchk(ctbic_pkg::OFF_TFLG, 8'h07);
    fail <= 3'h0;
    rdchk(ctbic_pkg::OFF_TAAK, 8'h04);
    xfer(1'b1, ctbic_pkg::OFF_TBSEL, 8'h00);
    rdchk(ctbic_pkg::OFF_TBSEL, 8'h00);
    cmp({fg_sel, fg_ok}, 0);
    // initialization mode
    xfer(1'b1, ctbic_pkg::OFF_RIER, 8'hFF);
    xfer(1'b1, ctbic_pkg::OFF_TBSEL, 8'h04);
    init_rq <= 1'b1;
    tick(3);
    rdchk(ctbic_pkg::OFF_TBSEL, 8'h04);
    init_ak <= 1'b1;
    tick(3);
    rdchk(ctbic_pkg::OFF_RIER, 8'h3C);
    rdchk(ctbic_pkg::OFF_TIER, 8'h00);
    rdchk(ctbic_pkg::OFF_TBSEL, 8'h00);
    xfer(1'b1, ctbic_pkg::OFF_RIER, 8'h00);
    xfer(1'b1, ctbic_pkg::OFF_TIER, 8'h07);
    rdchk(ctbic_pkg::OFF_RIER, 8'h3C);
    rdchk(ctbic_pkg::OFF_TIER, 8'h00);
    init_rq <= 1'b0;
    init_ak <= 1'b0;
    xfer(1'b1, ctbic_pkg::OFF_TIER, 8'h02);
    rdchk(ctbic_pkg::OFF_TIER, 8'h02);
    final_report();
  end
endmodule
`default_nettype wire
